// file: design/ext_irq_params.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          external request block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus.
// Notes: Definitions only.
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH

`define OFS_PRIORITY_SELECT_B 4'h0
`define OFS_EXT_REQUEST_STATUS 4'h4
`define OFS_EXT_REQUEST_ENABLE 4'h8
`define OFS_EXT_SENSE_CONTROL 4'hC
`define RST_REG8 8'h00
`define BIT_SERIAL0_PRI 3
`define BIT_SERIAL1_PRI 2
`define BIT_SERIAL2_PRI 1
`define STATUS_WMASK 8'h3F
`define REQ_COUNT 6
`define VECTOR_BASE 5'h0C
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: design/ext_irq_pkg.sv
// Purpose: Types of the external request block.
// Assumes: Nothing beyond the parameter header.
// Notes: The write path state is a small enum.
package ext_irq_pkg;
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_type;
endpackage

// file: design/ext_irq_detect_and_priority.sv
// Purpose: Six external active-low request pins with sense select,
//          pending flags, enables and the low half of priority reg B.
//          The upper priority bits and the arbiter sit outside.
// Assumes: Request pins are asynchronous; one 250 MHz clock.
//          Acknowledge pulses and standby come from logic on this clock.
// Notes: Registers reached over AXI4-Lite, one word each.
//        Standby clears every register but leaves the bus running.
//        Flags latch while disabled; only the request output is gated.
//        A set event in the clearing cycle keeps the flag set.
//        Bits 7 and 6 of enable and sense are storage only.
//
// Behaviour
// - Bit 3 sets serial channel 0 priority.
// - Bit 2 sets serial channel 1 priority.
// - Bit 1 sets serial channel 2 priority.
// - Bit 0 is plain storage, no effect.
// - Status clears on reset and standby.
// - Status bits 7 and 6 read zero.
// - Zero written after reading set clears flag.
// - Level mode: handling with pin high clears.
// - Edge mode: handling clears the flag.
// - Level mode: pin low sets flag.
// - Edge mode: falling pin sets flag.
// - Enable register clears on reset and standby.
// - Enable bits 7 and 6 are plain storage.
// - Enable bits 5 to 0 gate requests.
// - Sense register clears on reset and standby.
// - Sense bits 7 and 6 are plain storage.
// - Sense bits select level or falling edge.
// - Requests 0 to 5 use vectors 12-17.
// - Detection ignores pin direction.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ext_irq_params.svh"

module ext_irq_detect_and_priority
    import ext_irq_pkg::*;
#(
    parameter int NREQ = `REQ_COUNT
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,

    // Hardware standby, holds the registers at their reset values
    input wire logic standby_i,

    // External request pins, active low, direction independent
    input wire logic [NREQ-1:0] ext_request_pin_n_i,

    // Exception handling acknowledge, one pulse per request line
    input wire logic [NREQ-1:0] handling_ack_i,

    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,

    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,

    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,

    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,

    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,

    // Requests to the priority logic
    output logic [NREQ-1:0] ext_request_o,
    output logic [4:0] ext_vector_o,
    output logic ext_vector_valid_o,
    output logic serial0_priority_sel_o,
    output logic serial1_priority_sel_o,
    output logic serial2_priority_sel_o
);

    // Software-visible registers.
    logic [7:0] priority_select_b;
    logic [7:0] ext_request_status;
    logic [7:0] ext_request_enable;
    logic [7:0] ext_sense_control;

    // Flags that a status read saw set, armed for a clearing write.
    logic [NREQ-1:0] read_while_set;

    // Pin synchroniser and the previous sample for edge detection.
    logic [NREQ-1:0] sync1;
    logic [NREQ-1:0] sync2;
    logic [NREQ-1:0] sync_prev;

    // Write channel state and the halves parked until both are in.
    wr_state_type wr_state;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_held;
    logic w_held;

    // Only whole aligned words decode; other offsets answer SLVERR.
    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a[1:0] == 2'b00);
    endfunction

    // Read mux of the four byte-wide registers; other words read 0.
    function automatic logic [7:0] reg_word(
        input logic [3:0] a,
        input logic [7:0] p,
        input logic [7:0] s,
        input logic [7:0] e,
        input logic [7:0] c
    );
        case (a)
            `OFS_PRIORITY_SELECT_B: reg_word = p;
            `OFS_EXT_REQUEST_STATUS: reg_word = s & `STATUS_WMASK;
            `OFS_EXT_REQUEST_ENABLE: reg_word = e;
            `OFS_EXT_SENSE_CONTROL: reg_word = c;
            default: reg_word = 8'h00;
        endcase
    endfunction

    // Second flop is the only reader of the first.
    // Reset to the idle high level, so no false fall follows reset.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= '1;
            sync2 <= '1;
            sync_prev <= '1;
        end else begin
            sync1 <= ext_request_pin_n_i;
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    wire [NREQ-1:0] sense_edge = ext_sense_control[NREQ-1:0];
    wire [NREQ-1:0] pin_low = ~sync2;
    wire [NREQ-1:0] fall = sync_prev & ~sync2;

    wire [NREQ-1:0] set_level = ~sense_edge & pin_low;
    wire [NREQ-1:0] set_edge = sense_edge & fall;
    wire [NREQ-1:0] set_any = set_level | set_edge;

    // In level mode a low pin sets the flag again every cycle, so a
    // clear only sticks once the pin has gone high.
    wire [NREQ-1:0] clr_level = ~sense_edge & handling_ack_i & sync2;
    wire [NREQ-1:0] clr_edge = sense_edge & handling_ack_i;

    // Write channel: address and data are taken in either order.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;

    // A parked half wins over the bus once it has been taken.
    wire [3:0] eff_addr = aw_held ? wr_addr : s_axi_awaddr;
    wire [31:0] eff_data = w_held ? wr_data : s_axi_wdata;
    wire [3:0] eff_strb = w_held ? wr_strb : s_axi_wstrb;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire do_write = (wr_state == WR_IDLE) && have_aw && have_w;

    // Only byte lane 0 carries register bits; upper lanes are ignored.
    wire wr_lane0 = do_write && eff_strb[0] && is_mapped(eff_addr);
    wire wr_pri = wr_lane0 && (eff_addr == `OFS_PRIORITY_SELECT_B);
    wire wr_sts = wr_lane0 && (eff_addr == `OFS_EXT_REQUEST_STATUS);
    wire wr_ena = wr_lane0 && (eff_addr == `OFS_EXT_REQUEST_ENABLE);
    wire wr_sns = wr_lane0 && (eff_addr == `OFS_EXT_SENSE_CONTROL);

    // Clearing needs a 0 written to a flag that a read saw set.
    wire [NREQ-1:0] clr_sw = wr_sts ?
        (read_while_set & ~eff_data[NREQ-1:0]) : '0;

    // Read channel. Reads change nothing except that a status read
    // arms the clearing write.
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rd_sts = ar_take && (s_axi_araddr == `OFS_EXT_REQUEST_STATUS);

    // A new event in the clearing cycle wins over the clear.
    // Flags keep latching while disabled; only the request is gated.
    wire [NREQ-1:0] next_flags = set_any |
        (ext_request_status[NREQ-1:0] & ~(clr_sw | clr_level | clr_edge));

    // Bits 7 and 6 are never stored, so they always read 0.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_request_status <= `RST_REG8;
        end else if (standby_i) begin
            ext_request_status <= `RST_REG8;
        end else begin
            ext_request_status <= {2'b00, next_flags};
        end
    end

    // A flag is armed for a clearing write only after a read saw it set.
    // A status write disarms every flag unless a status read is taken in the
    // same cycle, so an old read cannot clear a flag that was set again afterwards.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            read_while_set <= '0;
        end else if (standby_i) begin
            read_while_set <= '0;
        end else if (rd_sts) begin
            read_while_set <= ext_request_status[NREQ-1:0];
        end else if (wr_sts) begin
            read_while_set <= '0;
        end else begin
            read_while_set <= read_while_set & next_flags;
        end
    end

    // Standby acts as a synchronous clear; the bus logic keeps going,
    // so a write that lands during standby is lost.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            priority_select_b <= `RST_REG8;
            ext_request_enable <= `RST_REG8;
            ext_sense_control <= `RST_REG8;
        end else if (standby_i) begin
            priority_select_b <= `RST_REG8;
            ext_request_enable <= `RST_REG8;
            ext_sense_control <= `RST_REG8;
        end else begin
            if (wr_pri) begin
                priority_select_b <= eff_data[7:0];
            end
            if (wr_ena) begin
                ext_request_enable <= eff_data[7:0];
            end
            if (wr_sns) begin
                ext_sense_control <= eff_data[7:0];
            end
        end
    end

    // Address and data that arrive apart are parked until the other
    // half is taken; the write then commits at that same edge.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_state <= WR_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    if (do_write) begin
                        wr_state <= WR_RESP;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= is_mapped(eff_addr) ?
                            `RESP_OKAY : `RESP_SLVERR;
                    end else begin
                        if (aw_take) begin
                            aw_held <= 1'b1;
                            wr_addr <= s_axi_awaddr;
                        end
                        if (w_take) begin
                            w_held <= 1'b1;
                            wr_data <= s_axi_wdata;
                            wr_strb <= s_axi_wstrb;
                        end
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state <= WR_IDLE;
                    end
                end
                default: wr_state <= WR_IDLE;
            endcase
        end
    end

    // Ready is registered so that every bus output comes from a flop.
    // Each ready stays low from its own handshake until the write has
    // been answered, so a second write waits until the response has been taken.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= (wr_state == WR_IDLE) && !do_write &&
                !aw_held && !aw_take;
            s_axi_wready <= (wr_state == WR_IDLE) && !do_write &&
                !w_held && !w_take;
        end
    end

    // One read at a time: arready stays low from the taken address
    // until the data has been accepted.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, reg_word(s_axi_araddr,
                priority_select_b, ext_request_status,
                ext_request_enable, ext_sense_control)};
            s_axi_rresp <= is_mapped(s_axi_araddr) ?
                `RESP_OKAY : `RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Lowest numbered pending request gives the vector, as the default
    // order favours smaller vector numbers.
    // It is worked out from next_flags so that it leaves the block in
    // the same cycle as the request lines that it belongs to.
    wire [NREQ-1:0] active = next_flags & ext_request_enable[NREQ-1:0];
    logic [4:0] next_vector;

    always_comb begin
        next_vector = 5'h00;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (active[i]) begin
                next_vector = `VECTOR_BASE + 5'(i);
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_request_o <= '0;
            ext_vector_o <= 5'h00;
            ext_vector_valid_o <= 1'b0;
            serial0_priority_sel_o <= 1'b0;
            serial1_priority_sel_o <= 1'b0;
            serial2_priority_sel_o <= 1'b0;
        end else begin
            ext_request_o <= standby_i ? '0 : active;
            // Standby zeroes the vector too, so vector and valid agree.
            ext_vector_o <= standby_i ? 5'h00 : next_vector;
            ext_vector_valid_o <= !standby_i && (|active);
            serial0_priority_sel_o <=
                priority_select_b[`BIT_SERIAL0_PRI];
            serial1_priority_sel_o <=
                priority_select_b[`BIT_SERIAL1_PRI];
            serial2_priority_sel_o <=
                priority_select_b[`BIT_SERIAL2_PRI];
        end
    end

endmodule

// file: tb/ext_irq_monitor.sv
// Purpose: Port-level checks of the external request block.
// Assumes: One clock domain; writes offer address and data together.
// Notes: Attached to every instance of the block by bind.
`timescale 1ns/10ps
`include "ext_irq_params.svh"
module ext_irq_monitor
    import ext_irq_pkg::*;
#(
    parameter int NREQ = 6
) (
    // Clock, reset and pins
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic standby_i,
    input wire logic [NREQ-1:0] ext_request_pin_n_i,
    input wire logic [NREQ-1:0] handling_ack_i,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Request outputs
    input wire logic [NREQ-1:0] ext_request_o,
    input wire logic [4:0] ext_vector_o,
    input wire logic ext_vector_valid_o,
    input wire logic serial0_priority_sel_o,
    input wire logic serial1_priority_sel_o,
    input wire logic serial2_priority_sel_o
);
    logic [2:0] want;
    logic [4:0] low;
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire pri_go = wr_go && s_axi_awaddr == `OFS_PRIORITY_SELECT_B
        && s_axi_wstrb[0] && !standby_i;
    wire [2:0] pri_now = {serial0_priority_sel_o, serial1_priority_sel_o,
        serial2_priority_sel_o};
    // Lowest active line wins, so scan downwards and keep the last hit.
    always_comb begin
        low = 5'h00;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (ext_request_o[i]) begin
                low = 5'(`VECTOR_BASE + i);
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (pri_go) begin
            want <= s_axi_wdata[3:1];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    property p_prio;
        pri_go |-> ##[2:3] (pri_now == want);
    endproperty
    a_prio: assert property (p_prio) else $error("priority wrong");
    property p_stby;
        standby_i ##1 standby_i |=> ext_request_o == '0 && pri_now == 3'h0;
    endproperty
    a_stby: assert property (p_stby) else $error("standby no clear");
    property p_valid;
        ext_vector_valid_o == (ext_request_o != '0);
    endproperty
    a_valid: assert property (p_valid) else $error("valid wrong");
    property p_vec;
        ext_vector_o == (ext_vector_valid_o ? low : 5'h00);
    endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_clear;
        ext_request_pin_n_i[0] [*5] ##0 handling_ack_i[0]
            |=> ##1 !ext_request_o[0];
    endproperty
    a_clear: assert property (p_clear) else $error("ack no clear");
    property p_stat;
        rd_go && s_axi_araddr == `OFS_EXT_REQUEST_STATUS
            |=> s_axi_rvalid && s_axi_rdata[31:6] == '0;
    endproperty
    a_stat: assert property (p_stat) else $error("status high bits");
    property p_slverr;
        rd_go && s_axi_araddr[1:0] != 2'b00
            |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unaligned read");
    property p_bresp;
        wr_go && s_axi_awaddr[1:0] == 2'b00
            |=> s_axi_bvalid && s_axi_bresp == `RESP_OKAY;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response");
    property p_arbusy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arbusy: assert property (p_arbusy) else $error("read not busy");
    c_prio: cover property (pri_go);
    c_vec: cover property ($rose(ext_vector_valid_o));
    c_ack: cover property (handling_ack_i[0] && ext_request_o[0]);
endmodule

bind ext_irq_detect_and_priority ext_irq_monitor #(.NREQ(NREQ))
    ext_irq_monitor_inst (.mclk_i, .nrst_i, .standby_i,
    .ext_request_pin_n_i, .handling_ack_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
    .s_axi_rresp, .ext_request_o, .ext_vector_o, .ext_vector_valid_o,
    .serial0_priority_sel_o, .serial1_priority_sel_o,
    .serial2_priority_sel_o);

// file: tb/ext_irq_pin_model.sv
// Purpose: External devices pulling the request pins low.
// Assumes: Each line has a pull-up, so a released line reads high.
// Notes: A pulse holds its lines low for pulse_len_i + 1 cycles.
`timescale 1ns/10ps
module ext_irq_pin_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Commands
    input wire logic [5:0] hold_low_i,
    input wire logic [5:0] pulse_i,
    input wire logic [3:0] pulse_len_i,
    // Request pins, active low
    output logic [5:0] pin_n_o
);
    logic [5:0] pulsing;
    logic [3:0] left;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pulsing <= 6'h00;
            left <= 4'h0;
        end else if (pulse_i != 6'h00) begin
            pulsing <= pulse_i;
            left <= pulse_len_i;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end else begin
            pulsing <= 6'h00;
        end
    end
    // Masking with reset keeps the pins high before the first edge.
    assign pin_n_o = ~(hold_low_i | (pulsing & {6{nrst_i}}));
endmodule

// file: tb/ext_irq_detect_and_priority_tb_top.sv
// Purpose: Self-checking bench of the external request block.
// Assumes: The pin model drives the pins; the bench is the bus master.
// Notes: Register values and pin masks are random from a fixed seed.
`timescale 1ns/10ps
`include "ext_irq_params.svh"
module ext_irq_detect_and_priority_tb_top;
    localparam logic [3:0] ofs_sts = `OFS_EXT_REQUEST_STATUS;
    localparam logic [3:0] ofs_ena = `OFS_EXT_REQUEST_ENABLE;
    localparam logic [3:0] ofs_sns = `OFS_EXT_SENSE_CONTROL;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic standby_i = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, got;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_vector_valid_o;
    logic serial0_priority_sel_o, serial1_priority_sel_o;
    logic serial2_priority_sel_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [5:0] ext_request_o, ext_request_pin_n_i, m;
    logic [5:0] handling_ack_i = 6'h00, hold_low = 6'h00, pulse = 6'h00;
    logic [3:0] pulse_len = 4'h2;
    logic [4:0] ext_vector_o;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    int seed = 32'h76809022;
    ext_irq_detect_and_priority ext_irq_detect_and_priority_inst (.*);
    ext_irq_pin_model ext_irq_pin_model_inst (.mclk_i(mclk_i),
        .nrst_i(nrst_i), .hold_low_i(hold_low), .pulse_i(pulse),
        .pulse_len_i(pulse_len), .pin_n_o(ext_request_pin_n_i));
    always #2 mclk_i = ~mclk_i;
    function automatic logic [31:0] reg_exp(input logic [3:0] a,
        input logic [31:0] v);
        return (a == ofs_sts) ? 32'h0 : {24'h0, v[7:0]};
    endfunction
    function automatic logic [31:0] vec_of(input logic [5:0] r);
        for (int i = 0; i < 6; i++) begin
            if (r[i]) begin
                return 32'(`VECTOR_BASE + i);
            end
        end
        return 32'h0;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rc(input string n, input logic [3:0] a,
        input logic [31:0] e);
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        resp = s_axi_rresp;
        if (a[1:0] == 2'b00) chk(n, e, s_axi_rdata);
    endtask
    task automatic ack(input logic [5:0] v);
        handling_ack_i <= v;
        @(posedge mclk_i);
        handling_ack_i <= 6'h00;
        repeat (3) @(posedge mclk_i);
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 4; i++) rc("reset", 4'(i * 4), 0);
        rc("unaligned", 4'h3, 0);
        chk("unaligned resp", 32'(`RESP_SLVERR), 32'(resp));
        $display("test reset done");
        repeat (8) begin
            for (int i = 3; i >= 0; i--) begin
                d = $random(seed);
                wr(4'(i * 4), d);
                rc("reg", 4'(i * 4), reg_exp(4'(i * 4), d));
            end
            got = {29'h0, serial0_priority_sel_o, serial1_priority_sel_o,
                serial2_priority_sel_o};
            chk("priority outputs", {29'h0, d[3:1]}, got);
        end
        $display("test registers done");
        wr(ofs_sns, 32'h0);
        wr(ofs_ena, 32'h3F);
        m = 6'($random(seed)) | 6'h01;
        hold_low <= m;
        repeat (6) @(posedge mclk_i);
        rc("level flags", ofs_sts, {26'h0, m});
        chk("requests", {26'h0, m}, {26'h0, ext_request_o});
        chk("vector", vec_of(m), {27'h0, ext_vector_o});
        chk("valid", 1, {31'h0, ext_vector_valid_o});
        wr(ofs_ena, 32'hC0);
        rc("latched flags", ofs_sts, {26'h0, m});
        chk("masked", 0, {26'h0, ext_request_o});
        chk("valid off", 0, {31'h0, ext_vector_valid_o});
        hold_low <= 6'h00;
        repeat (6) @(posedge mclk_i);
        wr(ofs_sts, 32'hFF);
        rc("one kept", ofs_sts, {26'h0, m});
        wr(ofs_sts, {26'h0, ~m});
        rc("cleared", ofs_sts, 0);
        $display("test level done");
        wr(ofs_sns, 32'hFF);
        wr(ofs_ena, 32'h3F);
        m = 6'($random(seed)) | 6'h01;
        pulse <= m;
        @(posedge mclk_i);
        pulse <= 6'h00;
        repeat (8) @(posedge mclk_i);
        rc("edge flags", ofs_sts, {26'h0, m});
        for (int i = 0; i < 6; i++) begin
            ack(6'(1 << i));
            m[i] = 1'b0;
            chk("edge ack", {26'h0, m}, {26'h0, ext_request_o});
        end
        $display("test edge done");
        wr(ofs_sns, 32'hC0);
        hold_low <= 6'h3F;
        repeat (6) @(posedge mclk_i);
        ack(6'h3F);
        chk("ack pin low", 32'h3F, {26'h0, ext_request_o});
        hold_low <= 6'h00;
        repeat (6) @(posedge mclk_i);
        ack(6'h3F);
        chk("ack pin high", 0, {26'h0, ext_request_o});
        $display("test ack done");
        wr(4'h0, 32'hFF);
        wr(ofs_sns, 32'h0);
        wr(ofs_ena, 32'hFF);
        hold_low <= 6'h3F;
        repeat (6) @(posedge mclk_i);
        hold_low <= 6'h00;
        repeat (4) @(posedge mclk_i);
        standby_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        standby_i <= 1'b0;
        for (int i = 0; i < 4; i++) rc("standby", 4'(i * 4), 0);
        $display("test standby done");
        give_verdict();
    end
endmodule
